//--- bench/test_alu_status_flags.sv
`timescale 1ns/1ps
`include "alu_status_flags_consts.svh"

module test_alu_status_flags;
   logic clock;
   logic sys_rst;
   logic [`ASF_ADDR_W-1:0] regAddr;
   logic [7:0] regWrData;
   logic regWr;
   logic regRd;
   logic [7:0] regRdData;
   logic aluValid;
   alu_status_flags_pkg::alu_op_t aluOp;
   logic [7:0] aluA;
   logic [7:0] aluB;
   logic aluToStatus;
   logic [7:0] aluResult;
   logic aluResultValid;
   logic watchdogKickInstr;
   logic sleepInstr;
   logic wdtTimeout;
   logic wdtExpiryFlag;
   logic sleepEnteredFlag;
   logic zeroFlag;
   logic nibbleCarryFlag;
   logic carryFlag;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   logic [7:0] d;

   alu_status_flags dut (
      .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .aluValid(aluValid),
      .aluOp(aluOp), .aluA(aluA), .aluB(aluB), .aluToStatus(aluToStatus),
      .aluResult(aluResult), .aluResultValid(aluResultValid),
      .watchdogKickInstr(watchdogKickInstr), .sleepInstr(sleepInstr),
      .wdtTimeout(wdtTimeout), .wdtExpiryFlag(wdtExpiryFlag),
      .sleepEnteredFlag(sleepEnteredFlag), .zeroFlag(zeroFlag),
      .nibbleCarryFlag(nibbleCarryFlag), .carryFlag(carryFlag)
   );

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // A hung handshake would otherwise stall the run forever
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         mismatches++;
         conclude();
      end
   end

   task automatic wr(input logic [12:0] a, input logic [7:0] v);
      @(posedge clock);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= v;
      @(posedge clock);
      regWr <= 1'b0;
   endtask

   // Write then read with no gap, as the bus allows
   task automatic wrrd(input logic [12:0] wa, input logic [12:0] ra, input logic [7:0] v,
                       output logic [7:0] o);
      @(posedge clock);
      regWr <= 1'b1;
      regAddr <= wa;
      regWrData <= v;
      @(posedge clock);
      regWr <= 1'b0;
      regRd <= 1'b1;
      regAddr <= ra;
      @(posedge clock);
      regRd <= 1'b0;
      #1 o = regRdData;
   endtask

   task automatic rd(input logic [12:0] a, output logic [7:0] v);
      @(posedge clock);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRd <= 1'b0;
      #1 v = regRdData;
   endtask

   function automatic logic [7:0] flags();
      return {3'h0, wdtExpiryFlag, sleepEnteredFlag, zeroFlag, nibbleCarryFlag, carryFlag};
   endfunction

   // Result is only judged when the op is not aimed at the flags register
   task automatic alu(input alu_status_flags_pkg::alu_op_t op, input logic [7:0] a,
                      input logic [7:0] b, input logic toS, input logic [7:0] res,
                      input logic [7:0] fl);
      @(posedge clock);
      aluValid <= 1'b1;
      aluOp <= op;
      aluA <= a;
      aluB <= b;
      aluToStatus <= toS;
      @(posedge clock);
      aluValid <= 1'b0;
      aluToStatus <= 1'b0;
      #1;
      chk(flags(), fl);
      chk({7'h0, aluResultValid}, {7'h0, ~toS});
      if (!toS)
         chk(aluResult, res);
   endtask

   task automatic ev(input logic k, input logic s, input logic t, input logic [7:0] fl);
      @(posedge clock);
      watchdogKickInstr <= k;
      sleepInstr <= s;
      wdtTimeout <= t;
      @(posedge clock);
      watchdogKickInstr <= 1'b0;
      sleepInstr <= 1'b0;
      wdtTimeout <= 1'b0;
      rd(13'h0003, d);
      chk(d, fl);
      chk({7'h0, sleepEnteredFlag}, {7'h0, fl[3]});
   endtask

   task automatic t_reset();
      rd(13'h0003, d);
      chk(d, 8'h18);
      @(posedge clock);
      #1 chk(regRdData, 8'h00);
   endtask

   task automatic t_add();
      alu(alu_status_flags_pkg::OP_ADD, 8'h0F, 8'h01, 1'b0, 8'h10, 8'h1A);
      alu(alu_status_flags_pkg::OP_ADD, 8'hFF, 8'h01, 1'b0, 8'h00, 8'h1F);
   endtask

   task automatic t_sub();
      alu(alu_status_flags_pkg::OP_SUB, 8'h05, 8'h06, 1'b0, 8'hFF, 8'h18);
      alu(alu_status_flags_pkg::OP_SUB, 8'h06, 8'h05, 1'b0, 8'h01, 8'h1B);
      alu(alu_status_flags_pkg::OP_SUB, 8'h07, 8'h07, 1'b0, 8'h00, 8'h1F);
   endtask

   task automatic t_status();
      wr(13'h0003, 8'h00);
      wr(13'h0003, 8'hE7);
      rd(13'h0003, d);
      chk(d, 8'h1F);
      wr(13'h0083, 8'h00);
      rd(13'h0103, d);
      chk(d, 8'h18);
      alu(alu_status_flags_pkg::OP_ADD, 8'h80, 8'h80, 1'b1, 8'h00, 8'h1D);
      wr(13'h0003, 8'h03);
      alu(alu_status_flags_pkg::OP_CLR, 8'h5A, 8'h00, 1'b1, 8'h00, 8'h1F);
      rd(13'h0003, d);
      chk(d, 8'h1F);
   endtask

   task automatic t_events();
      ev(1'b0, 1'b1, 1'b0, 8'h17);
      ev(1'b0, 1'b0, 1'b1, 8'h07);
      ev(1'b1, 1'b0, 1'b0, 8'h1F);
   endtask

   task automatic t_ram();
      wr(13'h0020, 8'hA5);
      wr(13'h00EF, 8'h5A);
      wr(13'h0070, 8'h3C);
      wr(13'h1010, 8'h77);
      rd(13'h1000, d);
      chk(d, 8'hA5);
      rd(13'h109F, d);
      chk(d, 8'h5A);
      rd(13'h00F0, d);
      chk(d, 8'h3C);
      rd(13'h0030, d);
      chk(d, 8'h77);
      rd(13'h000C, d);
      chk(d, 8'h00);
      wrrd(13'h007A, 13'h017A, 8'hC6, d);
      chk(d, 8'hC6);
   endtask

   task automatic t_logic();
      alu(alu_status_flags_pkg::OP_IOR, 8'h12, 8'h00, 1'b0, 8'h12, 8'h1B);
      alu(alu_status_flags_pkg::OP_AND, 8'hF0, 8'h0F, 1'b0, 8'h00, 8'h1F);
      alu(alu_status_flags_pkg::OP_XOR, 8'h5A, 8'h0F, 1'b0, 8'h55, 8'h1B);
      alu(alu_status_flags_pkg::OP_MOV, 8'h00, 8'h00, 1'b0, 8'h00, 8'h1B);
      alu(alu_status_flags_pkg::OP_SWAP, 8'h3C, 8'h00, 1'b0, 8'hC3, 8'h1B);
      alu(alu_status_flags_pkg::OP_IOR, 8'h06, 8'h00, 1'b1, 8'h00, 8'h1A);
      alu(alu_status_flags_pkg::OP_MOV, 8'h05, 8'h00, 1'b1, 8'h00, 8'h1D);
   endtask

   // Software write and an instruction aimed at the flags register in one cycle
   task automatic t_clash();
      @(posedge clock);
      regWr <= 1'b1;
      regAddr <= 13'h0003;
      regWrData <= 8'h00;
      aluValid <= 1'b1;
      aluOp <= alu_status_flags_pkg::OP_ADD;
      aluA <= 8'hFF;
      aluB <= 8'h01;
      aluToStatus <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
      aluValid <= 1'b0;
      aluToStatus <= 1'b0;
      #1 chk(flags(), 8'h1F);
      @(posedge clock);
      regWr <= 1'b1;
      aluValid <= 1'b1;
      aluOp <= alu_status_flags_pkg::OP_CLR;
      aluToStatus <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
      aluValid <= 1'b0;
      aluToStatus <= 1'b0;
      #1 chk(flags(), 8'h1F);
   endtask

   initial
   begin
      sys_rst = 1'b0;
      regAddr = '0;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      aluValid = 1'b0;
      aluOp = alu_status_flags_pkg::OP_ADD;
      aluA = 8'h00;
      aluB = 8'h00;
      aluToStatus = 1'b0;
      watchdogKickInstr = 1'b0;
      sleepInstr = 1'b0;
      wdtTimeout = 1'b0;
      // A clean rising edge so the asynchronous reset is seen before the first clock
      #1 sys_rst = 1'b1;
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      t_reset();
      t_add();
      t_sub();
      t_status();
      t_events();
      t_ram();
      t_logic();
      t_clash();
      conclude();
   end
endmodule

//--- verilog/alu_status_flags.sv
// What this block does
// - Clear-file on flags register gives 000u u1uu.
// - Subtraction reports borrow in carry and nibble carry.
// - Borrow polarity reversed: cleared flag means borrow.
// - Subtract by adding two's complement of operand.
// - Upper three flag bits always read zero.
// - Power-on sets timeout, power-down; clears arithmetic flags.
// - Nibble carry follows carry out of bit three.
// - Carry follows carry out of the top bit.
// - Eighty bytes of general RAM per bank.
// - Sixteen common bytes shared by every bank.
// - General RAM also reachable as one linear space.
// - Flag-affecting op to flags register blocks those bits.
// - Timeout and power-down flags ignore software writes.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`include "alu_status_flags_consts.svh"

module alu_status_flags #(
   parameter int NUM_BANKS = `ASF_NUM_BANKS
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Register port
   input wire logic [`ASF_ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   // Instruction datapath
   input wire logic aluValid,
   input wire alu_status_flags_pkg::alu_op_t aluOp,
   input wire logic [7:0] aluA,
   input wire logic [7:0] aluB,
   input wire logic aluToStatus,
   output logic [7:0] aluResult,
   output logic aluResultValid,
   // Core events
   input wire logic watchdogKickInstr,
   input wire logic sleepInstr,
   input wire logic wdtTimeout,
   // Flags
   output logic wdtExpiryFlag,
   output logic sleepEnteredFlag,
   output logic zeroFlag,
   output logic nibbleCarryFlag,
   output logic carryFlag
);

   localparam int GPR_TOTAL = NUM_BANKS * `ASF_GPR_BYTES;

   alu_status_flags_pkg::core_state_t st_reg;
   alu_status_flags_pkg::core_state_t st_next;

   logic [7:0] gpRam [GPR_TOTAL];
   logic [7:0] commonRam [`ASF_COMMON_BYTES];

   // Bank-relative offset to flat general RAM index, used by banked access only; linear access takes the address as index
   function automatic logic [11:0] gprIndex(input logic [4:0] bank, input logic [6:0] off);
      logic [6:0] rel;
      rel = off - `ASF_GPR_BASE;
      gprIndex = 12'(12'(bank) * 12'd`ASF_GPR_BYTES) + 12'(rel);
   endfunction

   function automatic logic isCommon(input logic [`ASF_ADDR_W-1:0] a);
      isCommon = !a[`ASF_LINEAR_BIT] && (a[6:0] >= `ASF_COMMON_BASE);
   endfunction

   // Returns valid flag and flat index for a general RAM address
   function automatic logic [12:0] gprDecode(input logic [`ASF_ADDR_W-1:0] a);
      logic ok;
      logic [11:0] idx;
      ok = 1'b0;
      idx = 12'h000;
      if (a[`ASF_LINEAR_BIT])
      begin
         idx = a[11:0];
         ok = int'(idx) < GPR_TOTAL;
      end
      else if (a[6:0] >= `ASF_GPR_BASE && a[6:0] <= `ASF_GPR_LAST)
      begin
         idx = gprIndex(a[11:7], a[6:0]);
         ok = int'(a[11:7]) < NUM_BANKS;
      end
      gprDecode = {ok, idx};
   endfunction

   logic [12:0] wrDec;
   logic [12:0] rdDec;
   logic [8:0] sum;
   logic [4:0] nibSum;
   logic [7:0] opB;
   logic opCarryIn;
   logic [7:0] res;
   logic arithOp;
   logic zeroOnly;

   assign wrDec = gprDecode(regAddr);
   assign rdDec = gprDecode(regAddr);

   always_comb
   begin
      st_next = st_reg;
      st_next.resultValid = 1'b0;
      // Subtraction runs through the adder with inverted operand and carry in
      opB = (aluOp == alu_status_flags_pkg::OP_SUB) ? ~aluB : aluB;
      opCarryIn = (aluOp == alu_status_flags_pkg::OP_SUB);
      sum = 9'(aluA) + 9'(opB) + 9'(opCarryIn);
      nibSum = 5'(aluA[3:0]) + 5'(opB[3:0]) + 5'(opCarryIn);
      arithOp = 1'b0;
      zeroOnly = 1'b0;
      unique case (aluOp)
         alu_status_flags_pkg::OP_ADD,
         alu_status_flags_pkg::OP_SUB:
         begin
            res = sum[7:0];
            arithOp = 1'b1;
         end
         alu_status_flags_pkg::OP_AND:
         begin
            res = aluA & aluB;
            zeroOnly = 1'b1;
         end
         alu_status_flags_pkg::OP_IOR:
         begin
            res = aluA | aluB;
            zeroOnly = 1'b1;
         end
         alu_status_flags_pkg::OP_XOR:
         begin
            res = aluA ^ aluB;
            zeroOnly = 1'b1;
         end
         alu_status_flags_pkg::OP_CLR:
         begin
            res = 8'h00;
            zeroOnly = 1'b1;
         end
         alu_status_flags_pkg::OP_MOV:
         begin
            res = aluA;
         end
         alu_status_flags_pkg::OP_SWAP:
         begin
            res = {aluA[3:0], aluA[7:4]};
         end
      endcase

      // Software write: only arithmetic flags take the data; an instruction aimed here wins
      if (regWr && !regAddr[`ASF_LINEAR_BIT] && regAddr[6:0] == `ASF_STATUS_OFF
          && !(aluValid && aluToStatus))
      begin
         st_next.zeroFlag = regWrData[`ASF_Z_BIT];
         st_next.nibbleCarryFlag = regWrData[`ASF_DC_BIT];
         st_next.carryFlag = regWrData[`ASF_C_BIT];
      end

      if (aluValid)
      begin
         st_next.result = res;
         st_next.resultValid = !aluToStatus;
         if (aluToStatus && aluOp != alu_status_flags_pkg::OP_CLR)
         begin
            // Bits not owned by the operation take the result
            st_next.zeroFlag = res[`ASF_Z_BIT];
            st_next.nibbleCarryFlag = res[`ASF_DC_BIT];
            st_next.carryFlag = res[`ASF_C_BIT];
         end
         if (arithOp || zeroOnly)
         begin
            // Overrides any write to the flags register
            st_next.zeroFlag = (res == 8'h00);
         end
         if (arithOp)
         begin
            st_next.nibbleCarryFlag = nibSum[4];
            st_next.carryFlag = sum[8];
         end
      end

      // Reset-cause flags move only on core events; set wins over clear
      if (wdtTimeout)
      begin
         st_next.wdtExpiryFlag = 1'b0;
      end
      if (sleepInstr)
      begin
         st_next.sleepEnteredFlag = 1'b0;
      end
      if (watchdogKickInstr || sleepInstr)
      begin
         st_next.wdtExpiryFlag = 1'b1;
      end
      if (watchdogKickInstr)
      begin
         st_next.sleepEnteredFlag = 1'b1;
      end

      // Read data stands one cycle after the strobe, zero otherwise
      st_next.rdData = 8'h00;
      if (regRd)
      begin
         if (!regAddr[`ASF_LINEAR_BIT] && regAddr[6:0] == `ASF_STATUS_OFF)
         begin
            st_next.rdData = {`ASF_UNIMPL_VAL, st_reg.wdtExpiryFlag,
               st_reg.sleepEnteredFlag, st_reg.zeroFlag, st_reg.nibbleCarryFlag,
               st_reg.carryFlag};
         end
         else if (isCommon(regAddr))
         begin
            st_next.rdData = commonRam[regAddr[3:0]];
         end
         else if (rdDec[12])
         begin
            st_next.rdData = gpRam[rdDec[11:0]];
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_reg <= '0;
         st_reg.wdtExpiryFlag <= `ASF_TO_RST;
         st_reg.sleepEnteredFlag <= `ASF_PD_RST;
         st_reg.zeroFlag <= `ASF_ARITH_RST;
         st_reg.nibbleCarryFlag <= `ASF_ARITH_RST;
         st_reg.carryFlag <= `ASF_ARITH_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Storage has no reset, as RAM contents are undefined after power-up
   always_ff @(posedge clock)
   begin
      if (regWr && isCommon(regAddr))
      begin
         commonRam[regAddr[3:0]] <= regWrData;
      end
      else if (regWr && wrDec[12])
      begin
         gpRam[wrDec[11:0]] <= regWrData;
      end
   end

   assign regRdData = st_reg.rdData;
   assign aluResult = st_reg.result;
   assign aluResultValid = st_reg.resultValid;
   assign wdtExpiryFlag = st_reg.wdtExpiryFlag;
   assign sleepEnteredFlag = st_reg.sleepEnteredFlag;
   assign zeroFlag = st_reg.zeroFlag;
   assign nibbleCarryFlag = st_reg.nibbleCarryFlag;
   assign carryFlag = st_reg.carryFlag;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   logic noEvents;
   assign noEvents = !watchdogKickInstr && !sleepInstr && !wdtTimeout;

   property p_clr_status;
      aluValid && aluToStatus && aluOp == alu_status_flags_pkg::OP_CLR
      |=> zeroFlag && nibbleCarryFlag == $past(nibbleCarryFlag)
          && carryFlag == $past(carryFlag);
   endproperty
   a_clr_status: assert property (p_clr_status)
      else $error("clear of flags register wrong");

   property p_sub_borrow;
      aluValid && aluOp == alu_status_flags_pkg::OP_SUB
      |=> carryFlag == ($past(aluA) >= $past(aluB))
          && nibbleCarryFlag == ($past(aluA[3:0]) >= $past(aluB[3:0]));
   endproperty
   a_sub_borrow: assert property (p_sub_borrow)
      else $error("borrow polarity wrong");

   property p_sub_result;
      aluValid && aluOp == alu_status_flags_pkg::OP_SUB && !aluToStatus
      |=> aluResultValid && aluResult == 8'($past(aluA) - $past(aluB));
   endproperty
   a_sub_result: assert property (p_sub_result)
      else $error("subtraction result wrong");

   property p_status_read;
      regRd && !regAddr[`ASF_LINEAR_BIT] && regAddr[6:0] == `ASF_STATUS_OFF
      |=> regRdData[7:5] == 3'h0 && regRdData[4:0] == $past({wdtExpiryFlag,
          sleepEnteredFlag, zeroFlag, nibbleCarryFlag, carryFlag});
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("flags register read wrong");

   property p_por;
      @(posedge clock) disable iff (1'b0)
      sys_rst |-> wdtExpiryFlag && sleepEnteredFlag && !zeroFlag
          && !nibbleCarryFlag && !carryFlag;
   endproperty
   a_por: assert property (p_por)
      else $error("power-on flag values wrong");

   property p_add_carry;
      aluValid && aluOp == alu_status_flags_pkg::OP_ADD
      |=> carryFlag == (9'($past(aluA)) + 9'($past(aluB)) > 9'h0FF)
          && nibbleCarryFlag == (5'($past(aluA[3:0])) + 5'($past(aluB[3:0])) > 5'h0F);
   endproperty
   a_add_carry: assert property (p_add_carry)
      else $error("add carry flags wrong");

   property p_zero;
      aluValid && aluOp != alu_status_flags_pkg::OP_MOV
          && aluOp != alu_status_flags_pkg::OP_SWAP
      |=> zeroFlag == ($past(res) == 8'h00);
   endproperty
   a_zero: assert property (p_zero)
      else $error("zero flag wrong");

   property p_write_blocked;
      regWr && regAddr[6:0] == `ASF_STATUS_OFF && aluValid && aluToStatus
          && aluOp == alu_status_flags_pkg::OP_ADD
      |=> carryFlag == (9'($past(aluA)) + 9'($past(aluB)) > 9'h0FF);
   endproperty
   a_write_blocked: assert property (p_write_blocked)
      else $error("flag write not blocked");

   property p_cause_locked;
      regWr && noEvents |=> $stable(wdtExpiryFlag) && $stable(sleepEnteredFlag);
   endproperty
   a_cause_locked: assert property (p_cause_locked)
      else $error("reset-cause flag written by software");

   property p_timeout;
      wdtTimeout && !watchdogKickInstr && !sleepInstr |=> !wdtExpiryFlag;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("timeout flag not cleared");

   property p_sleep;
      sleepInstr && !watchdogKickInstr |=> !sleepEnteredFlag && wdtExpiryFlag;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("sleep flag update wrong");

   sequence s_common_write;
      regWr && isCommon(regAddr);
   endsequence

   sequence s_common_reread;
      regRd && isCommon(regAddr) && regAddr[3:0] == $past(regAddr[3:0]);
   endsequence

   property p_common;
      s_common_write ##1 s_common_reread |=> regRdData == $past(regWrData, 2);
   endproperty
   a_common: assert property (p_common)
      else $error("common RAM not shared");

endmodule

//--- verilog/alu_status_flags_consts.svh
`ifndef ALU_STATUS_FLAGS_CONSTS_SVH
`define ALU_STATUS_FLAGS_CONSTS_SVH

// Banked address: {linear, bank[4:0], offset[6:0]}
`define ASF_ADDR_W 13
`define ASF_LINEAR_BIT 12
`define ASF_STATUS_OFF 7'h03
`define ASF_GPR_BASE 7'h20
`define ASF_GPR_LAST 7'h6F
`define ASF_GPR_BYTES 80
`define ASF_COMMON_BASE 7'h70
`define ASF_COMMON_BYTES 16
`define ASF_NUM_BANKS 32

// Flag positions in the flags register
`define ASF_TO_BIT 4
`define ASF_PD_BIT 3
`define ASF_Z_BIT 2
`define ASF_DC_BIT 1
`define ASF_C_BIT 0

// Values at power-on and brown-out
`define ASF_TO_RST 1'h1
`define ASF_PD_RST 1'h1
`define ASF_ARITH_RST 1'h0
`define ASF_UNIMPL_VAL 3'h0

`endif

//--- verilog/alu_status_flags_pkg.sv
package alu_status_flags_pkg;

   typedef enum logic [2:0] {
      OP_ADD = 3'h0,
      OP_SUB = 3'h1,
      OP_AND = 3'h2,
      OP_IOR = 3'h3,
      OP_XOR = 3'h4,
      OP_CLR = 3'h5,
      OP_MOV = 3'h6,
      OP_SWAP = 3'h7
   } alu_op_t;

   typedef struct packed {
      logic wdtExpiryFlag;
      logic sleepEnteredFlag;
      logic zeroFlag;
      logic nibbleCarryFlag;
      logic carryFlag;
      logic [7:0] rdData;
      logic [7:0] result;
      logic resultValid;
   } core_state_t;

endpackage
